// ---- dv/tb_vid_dispatch.sv ----
// Self-checking bench for the interrupt dispatch block
`timescale 1ns/10ps
`default_nettype none
module tb_vid_dispatch;
  import vid_pkg::*;
  localparam int PF = 20; // Short power-fail delay
  logic mclk_i = 1'b0, reset_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
  vid_ops_t ops_i = '0;
  logic boundary_i = 1'b1, missing_mem_i = 1'b0, mem_parity_i = 1'b0, xfer_parity_i = 1'b0;
  logic [15:0] pc_i = 16'h1234, mem_rdata_i, ext_vec_i, jump_pc_o, dev_vec = 16'h0000;
  vid_mem_req_t mem_o;
  logic mem_ack_i, ext_req_i, int_ack_o, busy_o, jump_o, halt_o, sys_clear_o, restart_o;
  logic power_fail_i = 1'b0, slow = 1'b0, dev_go = 1'b0;
  int num_errors = 0, comparisons = 0, cycles = 0, jumps = 0;
  logic [3:0] ev;
  assign ev = {restart_o, sys_clear_o, halt_o, jump_o};
  always #5 mclk_i = ~mclk_i;
  vid_dispatch #(.PF_CYC(PF), .RTC60_CYC(30), .RTC50_CYC(40)) uut (.mclk_i(mclk_i),
    .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .ops_i(ops_i), .boundary_i(boundary_i),
    .pc_i(pc_i), .missing_mem_i(missing_mem_i), .mem_parity_i(mem_parity_i),
    .xfer_parity_i(xfer_parity_i), .mem_o(mem_o), .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i), .ext_req_i(ext_req_i), .ext_vec_i(ext_vec_i),
    .int_ack_o(int_ack_o), .power_fail_i(power_fail_i), .busy_o(busy_o), .jump_o(jump_o),
    .jump_pc_o(jump_pc_o), .halt_o(halt_o), .sys_clear_o(sys_clear_o), .restart_o(restart_o));
  vid_mem_model mdl (.mclk_i(mclk_i), .reset_i(reset_i), .mem_i(mem_o), .slow_i(slow),
    .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i), .dev_go_i(dev_go), .dev_vec_i(dev_vec),
    .int_ack_i(int_ack_o), .ext_req_o(ext_req_i), .ext_vec_o(ext_vec_i));
  // Jump pulse count and run limit
  always @(posedge mclk_i) begin
    cycles++;
    if (jump_o === 1'b1) jumps++;
    if (cycles == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task give_verdict;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tick
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task rd_check(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    check(reg_rdata_o, exp);
  endtask : rd_check
  task op(input vid_ops_t o);
    @(posedge mclk_i);
    ops_i <= o;
    @(posedge mclk_i);
    ops_i <= '0;
  endtask : op
  task ext(input logic [15:0] v);
    @(posedge mclk_i);
    dev_vec <= v;
    dev_go <= 1'b1;
    @(posedge mclk_i);
    dev_go <= 1'b0;
  endtask : ext
  // Bounded wait for one of jump, halt, clear, restart
  task wait_ev(input int sel, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge mclk_i);
      #1;
      if (ev[sel] === 1'b1) break;
    end
    check(i < lim, 1);
  endtask : wait_ev
  // Vector word read, PC stored at its target, resume after it
  task taken(input logic [15:0] vec, input logic [15:0] w);
    wait_ev(0, 100);
    check(mdl.last_rd, vec);
    check(jump_pc_o, w + 16'h0001);
    check(mdl.mem[w], pc_i);
  endtask : taken
  task rtc_step(input int per);
    int k;
    logic [15:0] v;
    v = mdl.mem[LOC_RTC];
    for (k = 0; k < 100 && mdl.mem[LOC_RTC] === v; k++) @(posedge mclk_i);
    v = mdl.mem[LOC_RTC];
    for (k = 0; k < 100 && mdl.mem[LOC_RTC] === v; k++) @(posedge mclk_i);
    check(k, per);
  endtask : rtc_step
  task s_standard;
    int j;
    rd_check(REG_STATUS, 8'h20);
    rd_check(4'h8, 8'h00);
    mdl.mem[VEC_EXT] = 16'h0500;
    j = jumps;
    ext(16'h0045);
    tick(20);
    boundary_i <= 1'b0;
    op(4'b1000);
    rd_check(REG_STATUS, 8'h21);
    tick(20);
    check(jumps, j);
    check(busy_o, 1'b0);
    boundary_i <= 1'b1;
    taken(VEC_EXT, 16'h0500);
    rd_check(REG_STATUS, 8'h00);
  endtask : s_standard
  task s_vectored;
    op(4'b0010);
    op(4'b1000);
    rd_check(REG_STATUS, 8'h03);
    slow <= 1'b1;
    mdl.mem[16'hffe0] = 16'h7ff0;
    ext(16'hffe0);
    taken(16'hffe0, 16'h7ff0);
    slow <= 1'b0;
  endtask : s_vectored
  task s_internal;
    @(posedge mclk_i) xfer_parity_i <= 1'b1;
    @(posedge mclk_i) xfer_parity_i <= 1'b0;
    rd_check(REG_STATUS, 8'h06);
    mdl.mem[VEC_MISSING] = 16'h0600;
    mdl.mem[16'h0045] = 16'h0700;
    boundary_i <= 1'b0;
    op(4'b1000);
    ext(16'h0045);
    @(posedge mclk_i) missing_mem_i <= 1'b1;
    @(posedge mclk_i) missing_mem_i <= 1'b0;
    tick(4);
    boundary_i <= 1'b1;
    taken(VEC_MISSING, 16'h0600);
    rd_check(REG_STATUS, 8'h02);
    op(4'b1000);
    taken(16'h0045, 16'h0700);
    wr(REG_CTRL, 8'h04);
    mdl.mem[VEC_PARITY] = 16'h0800;
    @(posedge mclk_i) mem_parity_i <= 1'b1;
    @(posedge mclk_i) mem_parity_i <= 1'b0;
    taken(VEC_PARITY, 16'h0800);
    rd_check(REG_STATUS, 8'h06);
    wr(REG_STATUS, 8'h04);
    rd_check(REG_STATUS, 8'h02);
  endtask : s_internal
  task s_rtc;
    op(4'b1000);
    op(4'b0101);
    rd_check(REG_STATUS, 8'h00);
    op(4'b0010);
    mdl.mem[LOC_RTC] = 16'hfffd;
    wr(REG_CTRL, 8'h01);
    rtc_step(30);
    wr(REG_CTRL, 8'h03);
    rtc_step(40);
    wr(REG_CTRL, 8'h00);
    check(mdl.mem[LOC_RTC], 16'h0001);
    op(4'b1000);
    taken(VEC_EXT, 16'h0500);
    tick(50);
    check(mdl.mem[LOC_RTC], 16'h0001);
  endtask : s_rtc
  task s_halt_power;
    op(4'b1000);
    ext(16'h0046);
    wait_ev(1, 100);
    check(busy_o, 1'b1);
    @(posedge mclk_i) reset_i <= 1'b1;
    tick(3);
    reset_i <= 1'b0;
    #1;
    check(halt_o, 1'b0);
    mdl.mem[VEC_POWER] = 16'h0900;
    wr(REG_CTRL, 8'h08);
    power_fail_i <= 1'b1;
    taken(VEC_POWER, 16'h0900);
    check(sys_clear_o, 1'b0);
    wait_ev(2, PF + 10);
    power_fail_i <= 1'b0;
    wait_ev(3, 20);
    wait_ev(0, 5);
    check(jump_pc_o, LOC_RESTART);
  endtask : s_halt_power
  initial begin
    tick(3);
    reset_i <= 1'b0;
    s_standard();
    s_vectored();
    s_internal();
    s_rtc();
    s_halt_power();
    give_verdict();
  end
endmodule : tb_vid_dispatch
`default_nettype wire

// ---- dv/vid_mem_model.sv ----
// Memory and backplane controller model facing the dispatch block
`timescale 1ns/10ps
`default_nettype none
module vid_mem_model
  import vid_pkg::*;
(
  input wire logic mclk_i,           // Clock
  input wire logic reset_i,          // Reset
  input wire vid_mem_req_t mem_i,    // Memory request
  input wire logic slow_i,           // Add wait cycles
  output logic mem_ack_o,            // Cycle done
  output logic [15:0] mem_rdata_o,   // Read data
  input wire logic dev_go_i,         // Controller wants service
  input wire logic [15:0] dev_vec_i, // Controller vector
  input wire logic int_ack_i,        // Grant from processor
  output logic ext_req_o,            // Request pin
  output logic [15:0] ext_vec_o      // Vector pins
);
  logic [15:0] mem [0:65535]; // Word store
  logic [15:0] last_rd = 16'h0000; // Last address read
  logic [15:0] vec_reg = 16'h0000; // Latched vector
  int cnt = 0; // Wait counter
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 16'h0000;
    mem_ack_o = 1'b0;
    mem_rdata_o = 16'h0000;
    ext_req_o = 1'b0;
  end
  // Memory cycles, prompt or slow; stale read data toggles
  always @(posedge mclk_i) begin
    mem_ack_o <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    if (reset_i) begin
      cnt <= 0;
    end else if (mem_i.req && !mem_ack_o) begin
      if (cnt >= (slow_i ? 3 : 0)) begin
        mem_ack_o <= 1'b1;
        cnt <= 0;
        if (mem_i.we) mem[mem_i.addr] <= mem_i.wdata;
        else begin
          mem_rdata_o <= mem[mem_i.addr];
          last_rd <= mem_i.addr;
        end
      end else cnt <= cnt + 1;
    end
  end
  // request held with vector until granted
  always @(posedge mclk_i) begin
    if (reset_i || int_ack_i) ext_req_o <= 1'b0;
    else if (dev_go_i) begin
      ext_req_o <= 1'b1;
      vec_reg <= dev_vec_i;
    end
  end
  assign ext_vec_o = ext_req_o ? vec_reg : ~vec_reg;
endmodule : vid_mem_model
`default_nettype wire

// ---- hw/vid_dispatch.sv ----
// Interrupt and trap dispatch with real-time clock counter
//
// Functional notes
// - Enable and inhibit set/clear external permit
// - Mode flag: vectored or standard dispatch
// - Standard mode jumps through word '63
// - Vectored mode uses controller supplied vector
// - Backplane position decides external priority
// - Zero vector word halts the processor
// - Vector word used as absolute address
// - Store PC at vector, resume after
// - Taking interrupt clears system-clear and permit keys
// - Nonexistent memory access raises missing-memory
// - Missing-memory uninhibitable, saves next PC
// - Missing-memory interrupt clears machine check flag
// - Memory read error raises parity condition
// - Internal or bus parity raises machine check
// - Power fail vectors '60, clear 1ms later
// - Battery restart at '1000 on power return
// - Clock increments word '61 each tick
// - Clock word reaching zero requests '63
// - Clock ignores permit, runs under I/O control
// - Compatible interrupt polls, inhibits further interrupts
// - Low words reserved for channels and vectors
// - Peripheral vectors '100-'177, normally '100+code
// - Internal always vectored, ignore external permit
// - Internal interrupts served before external
// - Supplied vector may be anywhere in 64K
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module vid_dispatch
  import vid_pkg::*;
#(
  parameter int PF_CYC = PF_CLEAR_CYC,   // Power fail to system clear
  parameter int RTC60_CYC = RTC_60HZ_CYC, // Clock tick at 60 Hz
  parameter int RTC50_CYC = RTC_50HZ_CYC  // Clock tick at 50 Hz
) (
  input wire logic mclk_i,               // Processor clock
  input wire logic reset_i,              // Synchronous reset
  input wire logic [3:0] reg_addr_i,     // Register address
  input wire logic [7:0] reg_wdata_i,    // Register write data
  input wire logic reg_wr_i,             // Register write strobe
  input wire logic reg_rd_i,             // Register read strobe
  output logic [7:0] reg_rdata_o,        // Register read data
  input wire vid_ops_t ops_i,            // Decoded instruction strobes
  input wire logic boundary_i,           // Instruction boundary
  input wire logic [15:0] pc_i,          // Next instruction address
  input wire logic missing_mem_i,        // Nonexistent location accessed
  input wire logic mem_parity_i,         // Parity error on memory read
  input wire logic xfer_parity_i,        // Parity error internal or bus
  output vid_mem_req_t mem_o,            // Memory request
  input wire logic mem_ack_i,            // Memory cycle done
  input wire logic [15:0] mem_rdata_i,   // Memory read data
  input wire logic ext_req_i,            // Backplane request pin
  input wire logic [15:0] ext_vec_i,     // Backplane vector pins
  output logic int_ack_o,                // Acknowledge to backplane chain
  input wire logic power_fail_i,         // Power monitor pin
  output logic busy_o,                   // Processor must stall
  output logic jump_o,                   // Load new PC pulse
  output logic [15:0] jump_pc_o,         // New PC value
  output logic halt_o,                   // Processor halted
  output logic sys_clear_o,              // Internal system clear
  output logic restart_o                 // Auto restart pulse
);
  // Elaboration check
  if (PF_CYC < 1 || RTC60_CYC < 1 || RTC50_CYC < 1) begin : g_chk
    $error("vid_dispatch: cycle counts must be at least one");
  end

  vid_state_t state_reg;        // Sequencer state
  logic [3:0] ctrl_reg;         // Control register
  logic permit_reg;             // Permit external interrupts key
  logic vectored_reg;           // External mode flag
  logic syskey_reg;             // System clear key
  logic mc_flag_reg;            // Machine check flag
  logic mm_pend_reg;            // Missing memory pending
  logic par_pend_reg;           // Parity interrupt pending
  logic pf_pend_reg;            // Power fail pending
  logic rtc_pend_reg;           // Clock overflow request
  logic rtc_due_reg;            // Clock tick to apply
  logic [15:0] vec_reg;         // Vector location in use
  logic [15:0] target_reg;      // Word read from vector
  logic [15:0] save_pc_reg;     // PC to deposit
  logic clr_mc_on_take_reg;     // Missing memory dispatch taken last cycle
  logic [1:0] req_s1, req_s2;   // Pin synchronisers: req, pf
  logic [15:0] vec_s1, vec_s2;  // Vector pin synchroniser
  logic pf_prev_reg;            // Previous power fail level
  logic [31:0] pf_cnt_reg;      // Power clear delay counter
  logic [31:0] rtc_cnt_reg;     // Clock tick counter
  logic take;                   // Dispatch starts this cycle
  logic take_int;               // An internal source wins
  logic take_ext;               // Backplane source wins
  logic take_rtc;               // Clock overflow source wins
  logic [15:0] take_vec;        // Chosen vector location
  logic rmc;                    // Software clears machine check
  logic [31:0] rtc_period;      // Current tick length

  // Two flip-flop synchronisers for pins
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      req_s1 <= 2'h0;
      req_s2 <= 2'h0;
      vec_s1 <= 16'h0000;
      vec_s2 <= 16'h0000;
    end else begin
      req_s1 <= {power_fail_i, ext_req_i};
      req_s2 <= req_s1;
      vec_s1 <= ext_vec_i;
      vec_s2 <= vec_s1;
    end
  end

  // Dispatch selection
  always_comb begin
    take_int = 1'b0;
    take_ext = 1'b0;
    take_rtc = 1'b0;
    take_vec = VEC_EXT;
    if (state_reg == S_IDLE && boundary_i && !halt_o && !restart_o) begin
      // internal first, never gated by permit
      if (pf_pend_reg) begin
        take_int = 1'b1;
        take_vec = VEC_POWER;
      end else if (mm_pend_reg) begin
        take_int = 1'b1;
        take_vec = VEC_MISSING;
      end else if (par_pend_reg) begin
        take_int = 1'b1;
        take_vec = VEC_PARITY;
      end else if (permit_reg && rtc_pend_reg) begin
        take_rtc = 1'b1;
        take_vec = VEC_EXT;
      end else if (permit_reg && req_s2[0]) begin
        take_ext = 1'b1;
        // vectored mode uses pins; standard uses '63
        take_vec = vectored_reg ? vec_s2 : VEC_EXT;
      end
    end
  end
  assign take = take_int | take_ext | take_rtc;
  assign rmc = reg_wr_i && reg_addr_i == REG_STATUS && reg_wdata_i[ST_MC_FLAG];
  assign rtc_period = ctrl_reg[CTRL_MAINS50] ? 32'(RTC50_CYC) : 32'(RTC60_CYC);

  // Control register write
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl_reg <= CTRL_RESET;
    end else if (reg_wr_i && reg_addr_i == REG_CTRL) begin
      // clock run bit under programmed I/O
      ctrl_reg <= reg_wdata_i[3:0];
    end
  end

  // Register read, data in the following cycle
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        REG_CTRL: reg_rdata_o <= {4'h0, ctrl_reg};
        REG_STATUS: reg_rdata_o <= {2'h0, syskey_reg, sys_clear_o, halt_o,
                                    mc_flag_reg, vectored_reg, permit_reg};
        default: reg_rdata_o <= 8'h00;  // Unmapped reads zero
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // Permit and mode keys
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      permit_reg <= 1'b0;
      vectored_reg <= 1'b0;
      syskey_reg <= 1'b1;
    end else begin
      // any dispatch clears both keys; inhibits further
      if (take) begin
        permit_reg <= 1'b0;
        syskey_reg <= 1'b0;
      end else if (ops_i.enable_external_interrupts) begin
        permit_reg <= 1'b1;
      end else if (ops_i.inhibit_external_interrupts) begin
        permit_reg <= 1'b0;
      end
      if (ops_i.enter_vectored_mode) begin
        vectored_reg <= 1'b1;
      end else if (ops_i.enter_standard_mode) begin
        vectored_reg <= 1'b0;
      end
    end
  end

  // Internal pending conditions, set wins over clear
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mm_pend_reg <= 1'b0;
      par_pend_reg <= 1'b0;
      mc_flag_reg <= 1'b0;
      clr_mc_on_take_reg <= 1'b0;
    end else begin
      mm_pend_reg <= missing_mem_i | (mm_pend_reg & ~(take_int && take_vec == VEC_MISSING));
      // parity interrupts only in check mode
      par_pend_reg <= ((mem_parity_i | xfer_parity_i) & ctrl_reg[CTRL_MC_MODE])
                      | (par_pend_reg & ~(take_int && take_vec == VEC_PARITY));
      clr_mc_on_take_reg <= take_int && take_vec == VEC_MISSING;
      if (mem_parity_i || xfer_parity_i) begin
        mc_flag_reg <= 1'b1;
      end else if (rmc || clr_mc_on_take_reg) begin
        mc_flag_reg <= 1'b0;
      end
    end
  end

  // Power fail detection and delayed system clear
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pf_prev_reg <= 1'b0;
      pf_pend_reg <= 1'b0;
      pf_cnt_reg <= 32'h0;
      sys_clear_o <= 1'b0;
      restart_o <= 1'b0;
    end else begin
      pf_prev_reg <= req_s2[1];
      restart_o <= 1'b0;
      if (req_s2[1] && !pf_prev_reg) begin
        pf_pend_reg <= 1'b1;
        pf_cnt_reg <= 32'(PF_CYC);
      end else begin
        if (take_int && take_vec == VEC_POWER) begin
          pf_pend_reg <= 1'b0;
        end
        if (pf_cnt_reg != 32'h0) begin
          pf_cnt_reg <= pf_cnt_reg - 32'h1;
          if (pf_cnt_reg == 32'h1) begin
            sys_clear_o <= 1'b1;
          end
        end
      end
      // restart on power return with battery
      if (sys_clear_o && !req_s2[1]) begin
        sys_clear_o <= 1'b0;
        restart_o <= ctrl_reg[CTRL_BATTERY];
      end
    end
  end

  // Real-time clock tick timer
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rtc_cnt_reg <= 32'h0;
      rtc_due_reg <= 1'b0;
    end else begin
      // runs by control bit only, ignores permit
      if (!ctrl_reg[CTRL_RTC_RUN]) begin
        rtc_cnt_reg <= 32'h0;
      end else if (rtc_cnt_reg >= rtc_period - 32'h1) begin
        rtc_cnt_reg <= 32'h0;
      end else begin
        rtc_cnt_reg <= rtc_cnt_reg + 32'h1;
      end
      // tick due, consumed by the memory update
      if (ctrl_reg[CTRL_RTC_RUN] && rtc_cnt_reg >= rtc_period - 32'h1) begin
        rtc_due_reg <= 1'b1;
      end else if (state_reg == S_RTCWR && mem_ack_i) begin
        rtc_due_reg <= 1'b0;
      end
    end
  end

  // Dispatch and clock update sequencer
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_reg <= S_IDLE;
      vec_reg <= 16'h0000;
      target_reg <= 16'h0000;
      save_pc_reg <= 16'h0000;
      rtc_pend_reg <= 1'b0;
      mem_o <= '0;
      jump_o <= 1'b0;
      jump_pc_o <= 16'h0000;
      halt_o <= 1'b0;
      int_ack_o <= 1'b0;
    end else begin
      jump_o <= 1'b0;
      int_ack_o <= 1'b0;
      if (restart_o) begin
        halt_o <= 1'b0;
        jump_o <= 1'b1;
        jump_pc_o <= LOC_RESTART;
        state_reg <= S_IDLE;
      end else begin
        case (state_reg)
          S_IDLE: begin
            if (take) begin
              vec_reg <= take_vec;
              save_pc_reg <= pc_i;
              int_ack_o <= take_ext;
              if (take_rtc) begin
                rtc_pend_reg <= 1'b0;
              end
              mem_o <= '{req: 1'b1, we: 1'b0, addr: take_vec, wdata: 16'h0000};
              state_reg <= S_VRD;
            end else if (rtc_due_reg && !halt_o) begin
              mem_o <= '{req: 1'b1, we: 1'b0, addr: LOC_RTC, wdata: 16'h0000};
              state_reg <= S_RTCRD;
            end
          end
          S_VRD: begin
            if (mem_ack_i) begin
              target_reg <= mem_rdata_i;
              if (mem_rdata_i == 16'h0000) begin
                mem_o <= '0;
                halt_o <= 1'b1;
                state_reg <= S_HALT;
              end else begin
                // deposit PC at the vector target
                mem_o <= '{req: 1'b1, we: 1'b1, addr: mem_rdata_i, wdata: save_pc_reg};
                state_reg <= S_PCWR;
              end
            end
          end
          S_PCWR: begin
            if (mem_ack_i) begin
              mem_o <= '0;
              state_reg <= S_JUMP;
            end
          end
          S_JUMP: begin
            jump_o <= 1'b1;
            jump_pc_o <= target_reg + 16'h0001;
            state_reg <= S_IDLE;
          end
          S_HALT: begin
            halt_o <= 1'b1;
          end
          S_RTCRD: begin
            if (mem_ack_i) begin
              mem_o <= '{req: 1'b1, we: 1'b1, addr: LOC_RTC,
                         wdata: mem_rdata_i + 16'h0001};
              state_reg <= S_RTCWR;
            end
          end
          S_RTCWR: begin
            if (mem_ack_i) begin
              // wrap to zero requests external interrupt
              if (mem_o.wdata == 16'h0000) begin
                rtc_pend_reg <= 1'b1;
              end
              mem_o <= '0;
              state_reg <= S_IDLE;
            end
          end
          default: begin
            mem_o <= '0;
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end

  // Processor stalls while the sequencer owns memory
  assign busy_o = (state_reg != S_IDLE) | take;

  // Vector fetch then PC store sequences
  sequence s_vec_fetch;
    state_reg == S_VRD && mem_ack_i && mem_rdata_i != 16'h0000;
  endsequence
  sequence s_pc_store;
    state_reg == S_PCWR && mem_o.we && mem_o.addr == target_reg;
  endsequence

  property p_permit_set;
    @(posedge mclk_i) disable iff (reset_i)
      ops_i.enable_external_interrupts && !take |=> permit_reg;
  endproperty
  a_permit_set: assert property (p_permit_set) else $error("permit not set");

  property p_take_keys;
    @(posedge mclk_i) disable iff (reset_i)
      take |=> !permit_reg && !syskey_reg;
  endproperty
  a_take_keys: assert property (p_take_keys) else $error("keys not cleared");

  property p_std_vec;
    @(posedge mclk_i) disable iff (reset_i)
      take_ext && !vectored_reg |=> vec_reg == VEC_EXT && mem_o.addr == VEC_EXT;
  endproperty
  a_std_vec: assert property (p_std_vec) else $error("standard vector wrong");

  property p_vect_vec;
    @(posedge mclk_i) disable iff (reset_i)
      take_ext && vectored_reg |=> vec_reg == $past(vec_s2) && int_ack_o;
  endproperty
  a_vect_vec: assert property (p_vect_vec) else $error("supplied vector unused");

  property p_zero_halt;
    @(posedge mclk_i) disable iff (reset_i)
      state_reg == S_VRD && mem_ack_i && mem_rdata_i == 16'h0000 && !restart_o
      |=> halt_o && !mem_o.req;
  endproperty
  a_zero_halt: assert property (p_zero_halt) else $error("zero vector no halt");

  property p_store_jump;
    @(posedge mclk_i) disable iff (reset_i || restart_o)
      s_vec_fetch |=> s_pc_store and mem_o.wdata == save_pc_reg;
  endproperty
  a_store_jump: assert property (p_store_jump) else $error("PC not deposited");

  property p_resume;
    @(posedge mclk_i) disable iff (reset_i || restart_o)
      state_reg == S_JUMP |=> jump_o && jump_pc_o == $past(target_reg) + 16'h0001;
  endproperty
  a_resume: assert property (p_resume) else $error("resume address wrong");

  property p_internal_first;
    @(posedge mclk_i) disable iff (reset_i)
      take && (pf_pend_reg || mm_pend_reg || par_pend_reg) |-> take_int && !take_ext;
  endproperty
  a_internal_first: assert property (p_internal_first) else $error("external first");

  property p_missing_clr;
    @(posedge mclk_i) disable iff (reset_i)
      take_int && take_vec == VEC_MISSING && !mem_parity_i && !xfer_parity_i
      ##1 !mem_parity_i && !xfer_parity_i |=> !mc_flag_reg;
  endproperty
  a_missing_clr: assert property (p_missing_clr) else $error("flag not cleared");

  property p_rtc_wrap;
    @(posedge mclk_i) disable iff (reset_i || restart_o)
      state_reg == S_RTCWR && mem_ack_i && mem_o.wdata == 16'h0000 |=> rtc_pend_reg;
  endproperty
  a_rtc_wrap: assert property (p_rtc_wrap) else $error("clock wrap lost");

  property p_pf_hold;
    @(posedge mclk_i) disable iff (reset_i)
      req_s2[1] && !pf_prev_reg && !sys_clear_o |=> pf_pend_reg ##1 !sys_clear_o;
  endproperty
  a_pf_hold: assert property (p_pf_hold) else $error("power clear early");

  property p_dedicated;
    @(posedge mclk_i) disable iff (reset_i)
      take_int |-> take_vec >= VEC_POWER && take_vec <= LOC_DEDIC_HI;
  endproperty
  a_dedicated: assert property (p_dedicated) else $error("internal vector out of range");
endmodule : vid_dispatch
`default_nettype wire

// ---- inc/vid_pkg.sv ----
// Package: constants, layouts and types of the interrupt dispatch block
`default_nettype none
package vid_pkg;
  // Fixed low-memory locations (octal comments)
  localparam logic [15:0] VEC_POWER = 16'h0030;    // '60 power failure
  localparam logic [15:0] LOC_RTC = 16'h0031;      // '61 clock counter word
  localparam logic [15:0] VEC_EXT = 16'h0033;      // '63 standard external
  localparam logic [15:0] VEC_MISSING = 16'h0036;  // '66 missing memory
  localparam logic [15:0] VEC_PARITY = 16'h0037;   // '67 parity / check
  localparam logic [15:0] LOC_RESTART = 16'h0200;  // '1000 auto restart
  localparam logic [15:0] LOC_CHAN_LO = 16'h0020;  // '40 channel words start
  localparam logic [15:0] LOC_CHAN_HI = 16'h002f;  // '57 channel words end
  localparam logic [15:0] LOC_DEDIC_HI = 16'h003c; // '74 dedicated vectors end
  localparam logic [15:0] LOC_PERIPH_LO = 16'h0040; // '100 peripheral vectors
  localparam logic [15:0] LOC_PERIPH_HI = 16'h007f; // '177 peripheral end
  // Timing
  localparam int CLK_MHZ = 100;              // Processor clock rate
  localparam int PF_CLEAR_US = 1000;         // Power fail to system clear
  localparam int RTC_60HZ_US = 16600;        // Clock tick, 60 Hz mains
  localparam int RTC_50HZ_US = 20000;        // Clock tick, 50 Hz mains
  localparam int PF_CLEAR_CYC = PF_CLEAR_US * CLK_MHZ;
  localparam int RTC_60HZ_CYC = RTC_60HZ_US * CLK_MHZ;
  localparam int RTC_50HZ_CYC = RTC_50HZ_US * CLK_MHZ;
  // Register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;    // Control
  localparam logic [3:0] REG_STATUS = 4'h4;  // Status, write 1 to bit 2 clears
  // Control fields
  localparam int CTRL_RTC_RUN = 0;
  localparam int CTRL_MAINS50 = 1;
  localparam int CTRL_MC_MODE = 2;
  localparam int CTRL_BATTERY = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // Status fields
  localparam int ST_PERMIT = 0;
  localparam int ST_VECTORED = 1;
  localparam int ST_MC_FLAG = 2;
  localparam int ST_HALTED = 3;
  localparam int ST_SYSCLR = 4;
  localparam int ST_SYSKEY = 5;
  // Memory request carrier
  typedef struct packed {
    logic req;          // Cycle requested
    logic we;           // Write
    logic [15:0] addr;  // Absolute word address
    logic [15:0] wdata; // Write data
  } vid_mem_req_t;
  // Instruction decode strobes
  typedef struct packed {
    logic enable_external_interrupts;
    logic inhibit_external_interrupts;
    logic enter_vectored_mode;
    logic enter_standard_mode;
  } vid_ops_t;
  // Dispatch sequencer states
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_VRD = 7'h02,
    S_PCWR = 7'h04,
    S_JUMP = 7'h08,
    S_HALT = 7'h10,
    S_RTCRD = 7'h20,
    S_RTCWR = 7'h40
  } vid_state_t;
endpackage : vid_pkg
`default_nettype wire
